// file: src/vfu_pkg.sv
package vfu_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] REG_CMD     = 8'h00;
    localparam logic [7:0] REG_VLEN    = 8'h04;
    localparam logic [7:0] REG_SCAL_LO = 8'h08;
    localparam logic [7:0] REG_SCAL_HI = 8'h0c;
    localparam logic [7:0] REG_STATUS  = 8'h10;
    localparam logic [7:0] REG_MASK_LO = 8'h14;
    localparam logic [7:0] REG_MASK_HI = 8'h18;

    // ----------------------------------------
    // Reset values, length limit and field positions
    // ----------------------------------------
    localparam logic [6:0]  VLEN_RESET  = 7'h40;
    localparam logic [6:0]  VLEN_MAX    = 7'h40;
    localparam logic [15:0] CMD_RESET   = 16'h0000;
    localparam int          STAT_REFUSE = 6;

    // ----------------------------------------
    // Opcode groups (7-bit op field)
    // ----------------------------------------
    localparam logic [3:0] OP_MUL_GRP = 4'he;
    localparam logic [4:0] OP_ADD_GRP = 5'h1e;
    localparam logic [6:0] OP_RCP     = 7'h7c;
    localparam logic [6:0] OP_MSK     = 7'h7d;

    // ----------------------------------------
    // Timing in clock periods
    // ----------------------------------------
    localparam logic [7:0] CHAIN_MUL  = 8'h09;
    localparam logic [7:0] CHAIN_ADD  = 8'h08;
    localparam logic [7:0] CHAIN_RCP  = 8'h10;
    localparam logic [7:0] CHAIN_POP  = 8'h08;
    localparam logic [7:0] REL_MIN    = 8'h05;
    localparam logic [7:0] BUSY_EXTRA = 8'h04;
    localparam logic [7:0] XFER_EXTRA = 8'h06;
    localparam int         PIPE_DEPTH = 16;

    // ----------------------------------------
    // Reciprocal constants
    // ----------------------------------------
    localparam logic [95:0] RCP_NUM     = 96'hffff_ffff_ffff_ffff_ffff_ffff;
    localparam logic [15:0] RCP_EXP_SUM = 16'h8001;
    localparam logic [47:0] RCP_KEEP    = 48'hffff_fffc_0000;

    typedef enum logic [2:0] {U_NONE, U_MUL, U_ADD, U_RCP, U_POP, U_PAR, U_MSK} vfu_unit_t;

    typedef struct packed {
        logic        v;
        logic [5:0]  idx;
        logic [63:0] data;
    } vfu_pipe_t;

endpackage

// file: src/vfu_fadd.sv
`timescale 1ns/1ps
module vfu_fadd
    import vfu_pkg::*;
(
    input  wire logic [63:0] opA,
    input  wire logic [63:0] opB,
    input  wire logic        subtract,
    output logic      [63:0] sum
);
    logic        bSign;
    logic        swap;
    logic        bigS;
    logic        smlS;
    logic        sgn;
    logic [14:0] bigE;
    logic [14:0] smlE;
    logic [14:0] diff;
    logic [47:0] bigC;
    logic [47:0] smlC;
    logic [47:0] smlSh;
    logic [48:0] raw;
    logic [5:0]  lz;

    always_comb
    begin
        bSign = opB[63] ^ subtract;
        swap  = opB[62:48] > opA[62:48];
        bigS  = swap ? bSign : opA[63];
        smlS  = swap ? opA[63] : bSign;
        bigE  = swap ? opB[62:48] : opA[62:48];
        smlE  = swap ? opA[62:48] : opB[62:48];
        bigC  = swap ? opB[47:0] : opA[47:0];
        smlC  = swap ? opA[47:0] : opB[47:0];
        diff  = bigE - smlE;
        // Far-apart exponents shift the small operand out entirely
        smlSh = (diff > 15'h0030) ? 48'h0 : (smlC >> diff);
        sgn   = bigS;
        if (bigS == smlS)
            raw = {1'b0, bigC} + {1'b0, smlSh};
        else if (bigC >= smlSh)
            raw = {1'b0, bigC - smlSh};
        else
        begin
            raw = {1'b0, smlSh - bigC};
            sgn = smlS;
        end
        lz = 6'h00;
        for (int i = 0; i < 48; i++)
            if (raw[i])
                lz = 6'(47 - i);
        if (raw[48])
            sum = {sgn, bigE + 15'h0001, raw[48:1]};
        else if (raw == 49'h0)
            sum = 64'h0;
        else
            sum = {sgn, bigE - 15'(lz), raw[47:0] << lz};
    end
endmodule // vfu_fadd

// file: src/vfu_units.sv
// Functional notes
// - Multiply results at VL+9, min 14, chain 9
// - 170/171 add, 172/173 subtract
// - Elements from 0, index steps by one
// - Add results always normalised
// - Scalar copied at issue, held throughout
// - Scalar designator zero means operand zero
// - Add: operands freed 5/VL, ready VL+8
// - 174ij0 writes 30-bit reciprocal approximations
// - Reciprocal ready VL+16, min 21, chain 16
// - Shared 174 unit blocks another 174
// - Popcount in low seven bits
// - Parity only into bit zero
// - Pop/parity ready VL+8, min 13, chain 8
// - Element 0 maps to mask bit 63
// - Only low two k bits select test
// - Zero, nonzero, positive, negative tests
// - Mask bits past VL cleared
// - Mask ready VL+4, transfer VL+6
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module vfu_units
    import vfu_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    output logic             srcReq,
    output logic      [5:0]  srcIndex,
    output logic      [2:0]  srcJSel,
    output logic      [2:0]  srcKSel,
    input  wire logic [63:0] srcJData,
    input  wire logic [63:0] srcKData,
    input  wire logic [63:0] fmulProduct,
    output logic             resValid,
    output logic      [5:0]  resIndex,
    output logic      [2:0]  resDest,
    output logic      [63:0] resData,
    output logic      [63:0] maskReg,
    output logic             busy,
    output logic             srcFree,
    output logic             resultReady,
    output logic             unitFree,
    output logic             maskReady,
    output logic             maskXferReady
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [15:0]                 cmd;
        logic [6:0]                  vlen;
        logic [63:0]                 scal;
        logic [63:0]                 hold;
        logic [63:0]                 mask;
        logic                        active;
        logic                        fresh;
        logic [7:0]                  cnt;
        vfu_unit_t                   unit;
        logic                        sub;
        logic                        useScal;
        logic [2:0]                  dest;
        logic [2:0]                  srcJ;
        logic [2:0]                  srcK;
        logic [1:0]                  cond;
        logic [6:0]                  vlr;
        logic                        srcFree;
        logic                        resRdy;
        logic                        unitFree;
        logic                        maskRdy;
        logic                        xferRdy;
        logic                        refused;
        vfu_pipe_t [PIPE_DEPTH-1:0]  pipe;
        logic                        dValid;
        logic                        dWrite;
        logic [7:0]                  dAddr;
        logic [31:0]                 rdata;
    } vfu_state_t;

    vfu_state_t  r;
    vfu_state_t  next_r;
    logic [7:0]  nc;
    logic [7:0]  relAt;
    logic [7:0]  resAt;
    logic [7:0]  doneAt;
    logic [7:0]  chainLen;
    logic        issueWr;
    vfu_unit_t   newUnit;
    logic [63:0] faddSum;
    logic [95:0] rcpQ;
    logic [14:0] rcpExp;
    logic [6:0]  popCnt;
    logic [63:0] elemRes;
    logic        maskBit;

    // ----------------------------------------
    // Decode and timing
    // ----------------------------------------
    function automatic vfu_unit_t decode(input logic [15:0] c);
        logic [6:0] op;
        op = c[15:9];
        if (op[6:3] == OP_MUL_GRP)
            return U_MUL;
        if (op[6:2] == OP_ADD_GRP)
            return U_ADD;
        if (op == OP_RCP)
        begin
            case (c[2:0])
                3'h0:    return U_RCP;
                3'h1:    return U_POP;
                3'h2:    return U_PAR;
                default: return U_NONE;
            endcase
        end
        if (op == OP_MSK)
            return U_MSK;
        return U_NONE;
    endfunction

    function automatic logic [31:0] readReg(input vfu_state_t s, input logic [7:0] a);
        case (a)
            REG_CMD:     return {16'h0, s.cmd};
            REG_VLEN:    return {25'h0, s.vlen};
            REG_SCAL_LO: return s.scal[31:0];
            REG_SCAL_HI: return s.scal[63:32];
            REG_STATUS:  return {25'h0, s.refused, s.xferRdy, s.maskRdy, s.unitFree,
                                 s.resRdy, s.srcFree, s.active};
            REG_MASK_LO: return s.mask[31:0];
            REG_MASK_HI: return s.mask[63:32];
            default:     return 32'h0;
        endcase
    endfunction

    always_comb
    begin
        case (r.unit)
            U_MUL:        chainLen = CHAIN_MUL;
            U_ADD:        chainLen = CHAIN_ADD;
            U_RCP:        chainLen = CHAIN_RCP;
            U_POP, U_PAR: chainLen = CHAIN_POP;
            default:      chainLen = 8'h00;
        endcase
    end

    assign nc      = r.cnt + 8'h01;
    assign relAt   = ({1'b0, r.vlr} > REL_MIN) ? {1'b0, r.vlr} : REL_MIN;
    assign resAt   = relAt + chainLen;
    assign doneAt  = (r.unit == U_MSK) ? {1'b0, r.vlr} + XFER_EXTRA : resAt;
    assign issueWr = r.dValid && r.dWrite && (r.dAddr == REG_CMD);
    assign newUnit = decode(hwdata[15:0]);

    // ----------------------------------------
    // Element datapath
    // ----------------------------------------
    // index is the period count
    assign srcReq   = r.active && (r.cnt < {1'b0, r.vlr});
    assign srcIndex = r.cnt[5:0];
    assign srcJSel  = r.srcJ;
    assign srcKSel  = r.srcK;

    vfu_fadd u_fadd (
        .opA      (r.useScal ? r.hold : srcJData),
        .opB      (srcKData),
        .subtract (r.sub),
        .sum      (faddSum)
    );

    // no check of coefficient bit 47
    assign rcpQ   = RCP_NUM / {48'h0, srcJData[47:0] | 48'h1};
    assign rcpExp = 15'(RCP_EXP_SUM - {1'b0, srcJData[62:48]});
    assign popCnt = 7'($countones(srcJData));

    always_comb
    begin
        case (r.unit)
            U_MUL:   elemRes = fmulProduct;
            U_ADD:   elemRes = faddSum;
            U_RCP:   elemRes = {srcJData[63], rcpExp, rcpQ[48:1] & RCP_KEEP};
            U_POP:   elemRes = {57'h0, popCnt};
            U_PAR:   elemRes = {63'h0, popCnt[0]};
            default: elemRes = 64'h0;
        endcase
    end

    always_comb
    begin
        case (r.cond)
            2'h0:    maskBit = (srcJData == 64'h0);
            2'h1:    maskBit = (srcJData != 64'h0);
            2'h2:    maskBit = !srcJData[63];
            default: maskBit = srcJData[63];
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_r       = r;
        next_r.fresh = 1'b0;
        for (int i = 0; i < PIPE_DEPTH - 1; i++)
            next_r.pipe[i] = r.pipe[i + 1];
        next_r.pipe[PIPE_DEPTH - 1] = '0;

        if (r.active)
        begin
            next_r.cnt = nc;
            if (nc == relAt)
                next_r.srcFree = 1'b1;
            if (nc == resAt && r.unit != U_MSK)
                next_r.resRdy = 1'b1;
            if (nc == {1'b0, r.vlr} + BUSY_EXTRA)
            begin
                next_r.unitFree = 1'b1;
                next_r.maskRdy  = (r.unit == U_MSK);
            end
            if (nc == {1'b0, r.vlr} + XFER_EXTRA && r.unit == U_MSK)
                next_r.xferRdy = 1'b1;
            if (srcReq)
            begin
                // element 0 lands in bit 63
                if (r.unit == U_MSK)
                    next_r.mask[6'h3f - r.cnt[5:0]] = maskBit;
                else
                    next_r.pipe[chainLen[3:0] - 4'h1] = '{1'b1, r.cnt[5:0], elemRes};
            end
            if (nc == doneAt)
                next_r.active = 1'b0;
        end

        if (r.dValid && r.dWrite)
        begin
            case (r.dAddr)
                REG_VLEN:    next_r.vlen = (hwdata[6:0] > VLEN_MAX) ? VLEN_MAX : hwdata[6:0];
                REG_SCAL_LO: next_r.scal[31:0] = hwdata;
                REG_SCAL_HI: next_r.scal[63:32] = hwdata;
                REG_STATUS:
                    if (hwdata[STAT_REFUSE])
                        next_r.refused = 1'b0;
                default:     next_r.cmd = next_r.cmd;
            endcase
        end

        if (issueWr)
        begin
            // Issue while busy is dropped; the issuer should have held it
            if (r.active || newUnit == U_NONE)
                next_r.refused = 1'b1;
            else
            begin
                next_r.cmd      = hwdata[15:0];
                next_r.unit     = newUnit;
                next_r.active   = 1'b1;
                next_r.fresh    = 1'b1;
                next_r.cnt      = 8'h00;
                next_r.vlr      = r.vlen;
                next_r.dest     = hwdata[8:6];
                next_r.srcJ     = hwdata[5:3];
                next_r.srcK     = hwdata[2:0];
                next_r.cond     = hwdata[1:0];
                next_r.sub      = hwdata[10];
                next_r.useScal  = !hwdata[9];
                next_r.hold     = (hwdata[5:3] == 3'h0) ? 64'h0 : r.scal;
                next_r.srcFree  = 1'b0;
                next_r.resRdy   = 1'b0;
                next_r.unitFree = 1'b0;
                next_r.maskRdy  = 1'b0;
                next_r.xferRdy  = 1'b0;
                if (newUnit == U_MSK)
                    next_r.mask = 64'h0;
            end
        end

        next_r.dValid = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1])
        begin
            next_r.dWrite = hwrite;
            next_r.dAddr  = haddr[7:0];
            next_r.rdata  = hwrite ? 32'h0 : readReg(r, haddr[7:0]);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r      <= '0;
            r.vlen <= VLEN_RESET;
            r.cmd  <= CMD_RESET;
        end
        else
            r <= next_r;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Zero-wait slave; read data comes from the address-phase capture
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = r.rdata;
    assign resValid      = r.pipe[0].v;
    assign resIndex      = r.pipe[0].idx;
    assign resData       = r.pipe[0].data;
    assign resDest       = r.dest;
    assign maskReg       = r.mask;
    assign busy          = r.active;
    assign srcFree       = r.srcFree;
    assign resultReady   = r.resRdy;
    assign unitFree      = r.unitFree;
    assign maskReady     = r.maskRdy;
    assign maskXferReady = r.xferRdy;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_fresh(vfu_unit_t u);
        r.fresh && r.unit == u && r.vlr != 7'h00;
    endsequence

    sequence s_first;
        resValid && resIndex == 6'h00;
    endsequence

    chk_mul_chain: assert property (s_fresh(U_MUL) |-> ##9 s_first)
        else $error("multiply first result not at 9");
    chk_add_chain: assert property (s_fresh(U_ADD) |-> ##8 s_first)
        else $error("add first result not at 8");
    chk_rcp_chain: assert property (s_fresh(U_RCP) |-> ##16 s_first)
        else $error("reciprocal first result not at 16");
    chk_pop_chain: assert property (s_fresh(U_POP) |-> ##8 s_first)
        else $error("popcount first result not at 8");
    chk_elem_order: assert property (
        resValid && $past(resValid) |-> resIndex == 6'($past(resIndex) + 6'h01))
        else $error("result index did not step by one");
    chk_src_free: assert property (
        $rose(srcFree) |-> r.cnt == (r.vlr > 7'h05 ? {1'b0, r.vlr} : 8'h05))
        else $error("operands released at wrong time");
    chk_mask_time: assert property (
        $rose(maskReady) |-> (r.cnt == {1'b0, r.vlr} + 8'h04) ##2 $rose(maskXferReady))
        else $error("mask ready timing wrong");
    chk_mask_tail: assert property (
        $rose(maskReady) |-> (r.mask << r.vlr) == 64'h0)
        else $error("mask bits beyond length not clear");
    chk_pop_width: assert property (
        resValid && r.unit == U_POP |-> resData[63:7] == 57'h0)
        else $error("popcount high bits not zero");
    chk_par_width: assert property (
        resValid && r.unit == U_PAR |-> resData[63:1] == 63'h0)
        else $error("parity high bits not zero");
    chk_add_norm: assert property (
        resValid && r.unit == U_ADD && resData[47:0] != 48'h0 |-> resData[47])
        else $error("add result not normalised");
    chk_scal_hold: assert property (r.active |=> $stable(r.hold))
        else $error("latched scalar changed during operation");
    chk_scal_zero: assert property (
        r.fresh && r.srcJ == 3'h0 |-> r.hold == 64'h0)
        else $error("scalar designator zero gave nonzero operand");
    chk_busy_block: assert property (
        r.active && issueWr |=> r.refused && r.cnt == $past(nc))
        else $error("issue accepted while busy");
endmodule // vfu_units

// file: sim/vfu_vreg_model.sv
`timescale 1ns/1ps
module vfu_vreg_model (
    input  wire logic        sys_clk,
    input  wire logic        srcReq,
    input  wire logic [5:0]  srcIndex,
    input  wire logic [2:0]  srcJSel,
    input  wire logic [2:0]  srcKSel,
    output logic      [63:0] srcJData,
    output logic      [63:0] srcKData,
    input  wire logic        resValid,
    input  wire logic [5:0]  resIndex,
    input  wire logic [2:0]  resDest,
    input  wire logic [63:0] resData
);
    // ----------------------------------------
    // Vector register file
    // ----------------------------------------
    logic [63:0] vr [8][64];
    logic [63:0] junk = 64'h0;

    // Idle read lines churn, so a late sample never sees good data
    always @(posedge sys_clk) junk <= ~junk ^ {58'h0, srcIndex};
    always_comb srcJData = srcReq ? vr[srcJSel][srcIndex] : junk;
    always_comb srcKData = srcReq ? vr[srcKSel][srcIndex] : ~junk;

    always @(posedge sys_clk) if (resValid) vr[resDest][resIndex] <= resData;
endmodule // vfu_vreg_model

// file: sim/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin numChecks++; if ((s) !== (e)) begin nFail++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb;
    import vfu_pkg::*;
    logic        sys_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic        srcReq, resValid, busy, srcFree, resultReady, unitFree;
    logic        maskReady, maskXferReady;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2, srcJSel, srcKSel, resDest;
    logic [5:0]  srcIndex, resIndex;
    logic [63:0] srcJData, srcKData, fmulProduct = 0, resData, maskReg, s;
    logic [15:0] c;
    int          nFail = 0, numChecks = 0, seed = 8158, vl, lat, n;

    vfu_units DUT (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .srcReq(srcReq), .srcIndex(srcIndex), .srcJSel(srcJSel), .srcKSel(srcKSel),
        .srcJData(srcJData), .srcKData(srcKData), .fmulProduct(fmulProduct),
        .resValid(resValid), .resIndex(resIndex), .resDest(resDest), .resData(resData),
        .maskReg(maskReg), .busy(busy), .srcFree(srcFree), .resultReady(resultReady),
        .unitFree(unitFree), .maskReady(maskReady), .maskXferReady(maskXferReady));
    vfu_vreg_model m (.sys_clk(sys_clk), .srcReq(srcReq), .srcIndex(srcIndex),
        .srcJSel(srcJSel), .srcKSel(srcKSel), .srcJData(srcJData), .srcKData(srcKData),
        .resValid(resValid), .resIndex(resIndex), .resDest(resDest), .resData(resData));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) fmulProduct <= {$random(seed), $random(seed)};

    // ----------------------------------------
    // Bench helpers
    // ----------------------------------------
    function automatic logic [63:0] norm();
        return {$random(seed), $random(seed)} | 64'h0000_8000_0000_0000 | 64'h0001 << 48;
    endfunction
    function automatic logic [63:0] expEl(int t, logic [63:0] x);
        case (t)
            0: return {57'h0, 7'($countones(x))};
            1: return {63'h0, ^x};
            2: return x;
            default: return {~x[63], x[62:0]};
        endcase
    endfunction
    function automatic logic [63:0] expMask(int l, int k);
        logic [63:0] r;
        logic [63:0] x;
        r = 64'h0;
        for (int e = 0; e < l; e++)
        begin
            x = m.vr[2][e];
            case (k & 3)
                0: r[63-e] = (x == 64'h0);
                1: r[63-e] = (x != 64'h0);
                2: r[63-e] = ~x[63];
                default: r[63-e] = x[63];
            endcase
        end
        return r;
    endfunction
    // Thirty kept bits, with slack of two to four kept units below the exact value
    function automatic logic rcpOk(logic [63:0] x, logic [63:0] y);
        logic [95:0] p;
        p = {48'h0, x[47:0]} * {48'h0, y[47:0]};
        return y[63:48] == {x[63], 15'(RCP_EXP_SUM - {1'b0, x[62:48]})}
            && p <= 96'h8000_0000_0000_0000_0000_0000
            && p > 96'h7fff_fff8_0000_0000_0000_0000;
    endfunction

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    // Issue and count periods from first busy cycle to the ready flag
    task automatic run(input logic [15:0] cmd, input int l, input int lt, input bit msk);
        ahb(1'b1, REG_VLEN, 32'(l), d);
        ahb(1'b1, REG_CMD, {16'h0, cmd}, d);
        #1;
        n = 0;
        while ((msk ? maskReady : resultReady) !== 1'b1 && n < 200)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHK("latency", lt, n)
        while (busy !== 1'b0 && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("flags", 3'h7, {srcFree, unitFree, msk ? maskXferReady : resultReady})
    endtask

    task automatic finishTest();
        if (nFail == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        nFail++;
        finishTest();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        for (int e = 0; e < 64; e++)
        begin
            m.vr[1][e] = norm();
            m.vr[2][e] = ($random(seed) & 3) == 0 ? 64'h0 : {$random(seed), $random(seed)};
            m.vr[3][e] = 64'h0;
        end
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        ahb(1'b0, REG_VLEN, 32'h0, d);
        `CHK("vlen reset", 32'h40, d)
        ahb(1'b0, 8'h1c, 32'h0, d);
        `CHK("unmapped", 32'h0, d)
        for (int t = 0; t < 16; t++)
        begin
            vl = t == 0 ? 64 : t == 1 ? 5 : t == 2 ? 6 : $unsigned($random(seed)) % 65;
            case (t)
                0: c = {7'h7c, 9'o421};
                1: c = {7'h7c, 9'o522};
                2: c = {7'h78, 9'o601};
                3: c = {7'h7a, 9'o701};
                4: c = {7'h71, 9'o411};
                13: c = {7'h7c, 9'o410};
                // Vector-vector forms against the all-zero register
                14: c = {7'h79, 9'o613};
                15: c = {7'h7b, 9'o731};
                default: c = {7'h7d, 3'h0, 3'h2, 3'(t - 5)};
            endcase
            lat = (vl > 5 ? vl : 5) + (t == 4 ? 9 : t == 13 ? 16 : 8);
            // next issue only once busy has dropped
            run(c, vl, (t > 4 && t < 13) ? vl + 4 : lat, t > 4 && t < 13);
            for (int e = 0; e < vl && (t < 4 || t > 13); e++)
            begin
                s = expEl(t & 3, m.vr[t < 2 ? 2 : 1][e]);
                `CHK("element", s, m.vr[4 + (t & 3)][e])
            end
            for (int e = 0; e < vl && t == 13; e++)
                `CHK("recip", 1'b1, rcpOk(m.vr[1][e], m.vr[4][e]))
            if (t > 4 && t < 13)
            begin
                `CHK("mask", expMask(vl, t - 5), maskReg)
                ahb(1'b0, REG_MASK_HI, 32'h0, d);
                `CHK("mask hi", expMask(vl, t - 5) >> 32, {32'h0, d})
            end
        end
        s = norm();
        ahb(1'b1, REG_SCAL_LO, s[31:0], d);
        ahb(1'b1, REG_SCAL_HI, s[63:32], d);
        ahb(1'b1, REG_VLEN, 32'h8, d);
        ahb(1'b1, REG_CMD, {16'h0, 7'h78, 9'o513}, d);
        ahb(1'b1, REG_SCAL_HI, ~s[63:32], d);
        repeat (30) @(posedge sys_clk);
        for (int e = 0; e < 8; e++)
            `CHK("scalar held", s, m.vr[5][e])
        ahb(1'b1, REG_CMD, {16'h0, 7'h7c, 9'o621}, d);
        ahb(1'b1, REG_CMD, {16'h0, 7'h7c, 9'o722}, d);
        ahb(1'b0, REG_STATUS, 32'h0, d);
        `CHK("refused", 1'b1, d[STAT_REFUSE])
        repeat (30) @(posedge sys_clk);
        ahb(1'b1, REG_STATUS, 32'h40, d);
        ahb(1'b0, REG_STATUS, 32'h0, d);
        `CHK("refused clear", 1'b0, d[STAT_REFUSE])
        ahb(1'b1, REG_CMD, 32'h0, d);
        ahb(1'b0, REG_STATUS, 32'h0, d);
        `CHK("bad opcode", 1'b1, d[STAT_REFUSE])
        // Reset in mid-operation must drop everything in flight
        ahb(1'b1, REG_CMD, {16'h0, 7'h7d, 9'o020}, d);
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        #1;
        `CHK("reset idle", 3'h0, {busy, resValid, srcReq})
        `CHK("reset mask", 64'h0, maskReg)
        ahb(1'b0, REG_VLEN, 32'h0, d);
        `CHK("reset vlen", 32'h40, d)
        finishTest();
    end
endmodule // tb
